/* File: bench/cpu_transfer_exchange_decode_tb.sv */
// Purpose: self-checking bench for the transfer/exchange decode block
// Assumes: flags bits 3:0 hold pc_ext; exts packs four nibbles
// Notes:   timing of each transfer is also watched by the checker
module cpu_transfer_exchange_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
  logic CLK = 0, RESET_N = 0, IRQ = 0, st = 0, OP_VALID, OP_READY, OP_DONE, WAITING, EA_VALID;
  logic BR_REQ = 0, BR_TAKEN = 0, BR_LONG = 0, FLAG_REQ = 0, EA_REQ = 0, REG_WR = 0, REG_RD = 0;
  logic [1:0] FLAG_CONV = 0, EA_MODE = 0, EA_INDEX_SEL = 0;
  logic [3:0] REG_ADDR = 0, BR_CYC_TAKEN = 4'h4, BR_CYC_NOT = 4'h3;
  logic [15:0] OP_CODE, st_code = 0, BR_OFFSET = 0, FLAG_DATA = 0, REG_WDATA = 0, REG_RDATA;
  logic [19:0] EA_OPERAND = 0, EA;
  int n_fail = 0, tests_run = 0, cycles = 0, cyc;

  always #5 CLK = ~CLK;

  prog_mem pm (.clk(CLK), .rst_n(RESET_N), .start(st), .code(st_code), .ready(OP_READY),
    .valid(OP_VALID), .op(OP_CODE));
  cpu_transfer_exchange_decode dut (.CLK(CLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
    .OP_CODE(OP_CODE), .OP_READY(OP_READY), .OP_DONE(OP_DONE), .WAITING(WAITING), .IRQ(IRQ),
    .BR_REQ(BR_REQ), .BR_TAKEN(BR_TAKEN), .BR_LONG(BR_LONG), .BR_OFFSET(BR_OFFSET),
    .BR_CYC_TAKEN(BR_CYC_TAKEN), .BR_CYC_NOT(BR_CYC_NOT), .FLAG_REQ(FLAG_REQ), .FLAG_CONV(FLAG_CONV),
    .FLAG_DATA(FLAG_DATA), .EA_REQ(EA_REQ), .EA_MODE(EA_MODE), .EA_INDEX_SEL(EA_INDEX_SEL),
    .EA_OPERAND(EA_OPERAND), .EA_VALID(EA_VALID), .EA(EA), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

  task final_report;
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      final_report;
    end
  end

  // ----------------------------------------------------------------
  // bus and handshake tasks
  // ----------------------------------------------------------------
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1;
    @(posedge CLK);
    REG_WR <= 0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1;
    @(posedge CLK);
    REG_RD <= 0;
    #1 `CHK(REG_RDATA, e)
  endtask

  task done_wait(input int lim);
    for (cyc = 0; cyc < lim; cyc++) begin
      @(posedge CLK);
      #1;
      if (OP_DONE === 1'b1) break;
    end
  endtask

  task op(input logic [15:0] c);
    @(posedge CLK);
    st <= 1;
    st_code <= c;
    @(posedge CLK);
    st <= 0;
    done_wait(10);
    `CHK(cyc + 1, 2)
  endtask

  task br(input logic t, l, input logic [15:0] o, input int n, input logic [15:0] pc);
    @(posedge CLK);
    BR_REQ <= 1;
    BR_TAKEN <= t;
    BR_LONG <= l;
    BR_OFFSET <= o;
    @(posedge CLK);
    BR_REQ <= 0;
    done_wait(10);
    `CHK(cyc + 2, n)
    rd(4'h8, pc);
  endtask

  task ea(input logic [1:0] s, m, input logic [19:0] o, e);
    @(posedge CLK);
    EA_REQ <= 1;
    EA_INDEX_SEL <= s;
    EA_MODE <= m;
    EA_OPERAND <= o;
    @(posedge CLK);
    EA_REQ <= 0;
    #1 `CHK(EA, e)
    `CHK(EA_VALID, 1'b1)
  endtask

  task fl(input logic [1:0] c, input logic [15:0] d, e);
    @(posedge CLK);
    FLAG_REQ <= 1;
    FLAG_CONV <= c;
    FLAG_DATA <= d;
    @(posedge CLK);
    FLAG_REQ <= 0;
    rd(4'h7, e);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    for (int r = 0; r < 9; r++) rd(4'(r), 16'h0000);
    rd(4'h9, 16'h0001);
    wr(4'h9, 16'hffff);
    rd(4'h9, 16'h0001);
    wr(4'hf, 16'h1234);
    rd(4'hf, 16'h0000);
  endtask

  task t_swap_bytes;
    wr(4'h0, 16'h12a5);
    wr(4'h7, 16'h5a50);
    op(16'h371a);
    rd(4'h0, 16'ha512);
    rd(4'h7, 16'h5a50);
  endtask

  task t_exchange;
    static logic [15:0] xo [7] = '{16'h277a, 16'h37cc, 16'h37dc, 16'h37ec, 16'h374c, 16'h375c, 16'h376c};
    static logic [3:0] xa [7] = '{0, 0, 0, 0, 1, 1, 1};
    static logic [3:0] xb [7] = '{1, 2, 3, 4, 2, 3, 4};
    for (int i = 0; i < 7; i++) begin
      for (int r = 0; r < 5; r++) wr(4'(r), 16'(16'h1111 * (r + 1)));
      op(xo[i]);
      rd(xa[i], 16'(16'h1111 * (xb[i] + 1)));
      rd(xb[i], 16'(16'h1111 * (xa[i] + 1)));
    end
    rd(4'h7, 16'h5a50);
  endtask

  task t_copies;
    wr(4'h0, 16'hbeef);
    wr(4'h5, 16'h0ab0);
    op(16'h37ad);
    rd(4'h0, 16'hbe0b);
    op(16'h37ae);
    rd(4'h0, 16'hbe0a);
    wr(4'h4, 16'h9876);
    op(16'h275e);
    rd(4'h3, 16'h9876);
    rd(4'h5, 16'h0aa0);
    wr(4'h3, 16'h0001);
    wr(4'h5, 16'h0030);
    op(16'h375e);
    rd(4'h6, 16'hffff);
    rd(4'h5, 16'h2030);
    op(16'h376e);
    rd(4'h6, 16'h9874);
    rd(4'h5, 16'h0030);
    op(16'h374e);
    rd(4'h6, 16'h3331);
    op(16'h0000);
    rd(4'h6, 16'h3331);
    rd(4'h7, 16'h5a50);
  endtask

  task t_wait;
    @(posedge CLK);
    st <= 1;
    st_code <= 16'h27f3;
    @(posedge CLK);
    st <= 0;
    repeat (10) @(posedge CLK);
    #1 `CHK(WAITING, 1'b1)
    `CHK(OP_DONE, 1'b0)
    @(posedge CLK);
    IRQ <= 1;
    done_wait(10);
    `CHK(OP_DONE, 1'b1)
    @(posedge CLK);
    IRQ <= 0;
  endtask

  task t_branch;
    wr(4'h8, 16'h0100);
    br(1, 0, 16'hff80, 4, 16'h0180);
    br(0, 1, 16'h0040, 3, 16'h0180);
    br(1, 1, 16'hff80, 4, 16'h0100);
    br(1, 1, 16'hfe00, 4, 16'hff00);
    rd(4'h7, 16'h5a5f);
  endtask

  task t_ea;
    wr(4'h2, 16'hfff0);
    wr(4'h3, 16'h8000);
    wr(4'h4, 16'h0010);
    wr(4'h5, 16'h0000);
    ea(0, 0, 20'hfff80, 20'h10070);
    ea(1, 1, 20'h5fffe, 20'h07ffe);
    ea(2, 2, 20'hffff0, 20'h00000);
    ea(3, 0, 20'h00001, 20'h0fff1);
  endtask

  task t_flags;
    wr(4'h7, 16'h1234);
    fl(1, 16'habcd, 16'habc4);
    fl(2, 16'h5678, 16'h5678);
    fl(3, 16'hfff9, 16'h5679);
    fl(0, 16'h0000, 16'h5679);
  endtask

  initial begin
    repeat (16) @(posedge CLK);
    RESET_N <= 1;
    t_reset;
    t_swap_bytes;
    t_exchange;
    t_copies;
    t_wait;
    t_branch;
    t_ea;
    t_flags;
    final_report;
  end
endmodule

/* File: bench/prog_mem.sv */
// Purpose: program memory model presenting one opcode at a time
// Assumes: start pulses only while the decoder is idle
// Notes:   opcode lines show the inverse of the last code once released
module prog_mem (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request from bench
  input  wire logic        start,
  input  wire logic [15:0] code,
  // opcode handshake
  input  wire logic        ready,
  output logic             valid,
  output logic      [15:0] op
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      op    <= 16'h0000;
    end else if (valid && ready) begin
      valid <= 1'b0;
      op    <= ~op;
    end else if (start) begin
      valid <= 1'b1;
      op    <= code;
    end
  end
endmodule

/* File: bench/xfer_check_sva.sv */
// Purpose: port timing checks for the transfer/exchange decode block
// Assumes: bench runs branches with counts 4 taken and 3 not taken
// Notes:   attached to the top module by bind at the foot of this file
module xfer_check (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // opcode handshake
  input wire logic        OP_VALID,
  input wire logic [15:0] OP_CODE,
  input wire logic        OP_READY,
  input wire logic        OP_DONE,
  input wire logic        WAITING,
  input wire logic        IRQ,
  // branch
  input wire logic        BR_REQ,
  input wire logic        BR_TAKEN,
  input wire logic [3:0]  BR_CYC_TAKEN,
  input wire logic [3:0]  BR_CYC_NOT,
  // effective address
  input wire logic        EA_REQ,
  input wire logic        EA_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire take = OP_READY && OP_VALID;
  wire brt  = OP_READY && !OP_VALID && BR_REQ;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  two_cycle_op_a: assert property (take && OP_CODE != 16'h27f3 |=> !OP_DONE ##1 OP_DONE)
    else $error("op not done in two cycles");
  busy_in_op_a: assert property (take |=> !OP_READY)
    else $error("ready during op");
  wait_count_a: assert property (take && OP_CODE == 16'h27f3 |=> !WAITING [*7] ##1 WAITING)
    else $error("wait state not after eight cycles");
  wait_wake_a: assert property (WAITING && $rose(IRQ) |=> !OP_DONE ##[1:6] OP_DONE)
    else $error("no wake on interrupt");
  done_pulse_a: assert property (OP_DONE |=> !OP_DONE)
    else $error("done longer than one cycle");
  ready_done_a: assert property (OP_DONE |-> OP_READY)
    else $error("not ready with done");
  ea_latency_a: assert property (EA_REQ |=> EA_VALID)
    else $error("address valid late");
  ea_cause_a: assert property (EA_VALID |-> $past(EA_REQ))
    else $error("address valid without request");
  br_taken_a: assert property (brt && BR_TAKEN && BR_CYC_TAKEN == 4'h4 |=> !OP_DONE [*3] ##1 OP_DONE)
    else $error("taken branch count wrong");
  br_not_a: assert property (brt && !BR_TAKEN && BR_CYC_NOT == 4'h3 |=> !OP_DONE [*2] ##1 OP_DONE)
    else $error("untaken branch count wrong");
endmodule

bind cpu_transfer_exchange_decode xfer_check chk (.CLK(CLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .OP_READY(OP_READY), .OP_DONE(OP_DONE), .WAITING(WAITING), .IRQ(IRQ),
  .BR_REQ(BR_REQ), .BR_TAKEN(BR_TAKEN), .BR_CYC_TAKEN(BR_CYC_TAKEN), .BR_CYC_NOT(BR_CYC_NOT),
  .EA_REQ(EA_REQ), .EA_VALID(EA_VALID));

/* File: logic/cpu_transfer_exchange_decode.v */
// Purpose: execute transfer, exchange and wait instructions, flag conventions,
//          indexed address and relative branch arithmetic
// Assumes: one instruction in flight; program memory holds OP_VALID until OP_READY
// Notes:   architectural registers are reachable through the register port
`include "xfer_exchange_defines.vh"

module cpu_transfer_exchange_decode (
  // clock and reset
  input  wire        CLK,
  input  wire        RESET_N,
  // opcode from program memory
  input  wire        OP_VALID,
  input  wire [15:0] OP_CODE,
  output wire        OP_READY,
  output wire        OP_DONE,
  output wire        WAITING,
  // interrupt pin
  input  wire        IRQ,
  // conditional branch
  input  wire        BR_REQ,
  input  wire        BR_TAKEN,
  input  wire        BR_LONG,
  input  wire [15:0] BR_OFFSET,
  input  wire [3:0]  BR_CYC_TAKEN,
  input  wire [3:0]  BR_CYC_NOT,
  // flag update
  input  wire        FLAG_REQ,
  input  wire [1:0]  FLAG_CONV,
  input  wire [15:0] FLAG_DATA,
  // effective address
  input  wire        EA_REQ,
  input  wire [1:0]  EA_MODE,
  input  wire [1:0]  EA_INDEX_SEL,
  input  wire [19:0] EA_OPERAND,
  output wire        EA_VALID,
  output wire [19:0] EA,
  // register port
  input  wire [3:0]  REG_ADDR,
  input  wire [15:0] REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output wire [15:0] REG_RDATA
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  localparam S_IDLE   = 4'b0001;
  localparam S_EXEC   = 4'b0010;
  localparam S_WAIT   = 4'b0100;
  localparam S_BRANCH = 4'b1000;

  reg  [3:0]  state_q,  state_d;
  reg  [3:0]  cnt_q,    cnt_d;
  reg  [15:0] op_q,     op_d;
  reg         ready_q,  ready_d;
  reg         done_q,   done_d;
  reg         br_tk_q,  br_tk_d;
  reg         br_lg_q,  br_lg_d;
  reg  [15:0] br_off_q, br_off_d;
  reg  [15:0] wacc_q,   wacc_d;
  reg  [15:0] sacc_q,   sacc_d;
  reg  [15:0] idx1_q,   idx1_d;
  reg  [15:0] idx2_q,   idx2_d;
  reg  [15:0] idx3_q,   idx3_d;
  reg  [3:0]  ext1_q,   ext1_d;
  reg  [3:0]  ext2_q,   ext2_d;
  reg  [3:0]  ext3_q,   ext3_d;
  reg  [3:0]  sext_q,   sext_d;
  reg  [15:0] sp_q,     sp_d;
  reg  [15:0] flags_q,  flags_d;
  reg  [15:0] pc_q,     pc_d;
  reg  [15:0] rdata_q;
  reg  [19:0] ea_q;
  reg         ea_vld_q;
  reg         irq_s1_q;
  reg         irq_s2_q;
  reg         irq_s3_q;

  wire        irq_seen;
  wire        apply;
  wire [19:0] ea_w;
  reg  [19:0] ea_base;
  reg  [19:0] stk_w;
  reg  [3:0]  br_cyc;
  reg  [19:0] pc_next;

  assign irq_seen = irq_s2_q & irq_s3_q;
  assign apply    = (state_q == S_EXEC) && (cnt_q == 4'h1);

  // --------------------------------------------------------------------
  // interrupt pin synchroniser
  // --------------------------------------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      irq_s3_q <= 1'b0;
    end else begin
      irq_s1_q <= IRQ;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
    end
  end

  // --------------------------------------------------------------------
  // effective address
  // --------------------------------------------------------------------
  always @* begin
    case (EA_INDEX_SEL)
      2'h0:    ea_base = {ext1_q, idx1_q};
      2'h1:    ea_base = {ext2_q, idx2_q};
      2'h2:    ea_base = {ext3_q, idx3_q};
      default: ea_base = {ext1_q, idx1_q};
    endcase
  end

  ea_gen u_ea_gen (
    .mode    (EA_MODE),
    .base    (ea_base),
    .operand (EA_OPERAND),
    .ea      (ea_w)
  );

  // --------------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------------
  always @* begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    op_d     = op_q;
    ready_d  = ready_q;
    done_d   = 1'b0;
    br_tk_d  = br_tk_q;
    br_lg_d  = br_lg_q;
    br_off_d = br_off_q;
    br_cyc   = BR_TAKEN ? BR_CYC_TAKEN : BR_CYC_NOT;
    case (state_q)
      S_IDLE: begin
        if (OP_VALID) begin
          op_d    = OP_CODE;
          ready_d = 1'b0;
          state_d = S_EXEC;
          cnt_d   = (OP_CODE == `OP_WAIT_FOR_IRQ) ? `CYC_WAIT - 4'h1 : `CYC_XFER - 4'h1;
        end else if (BR_REQ) begin
          br_tk_d  = BR_TAKEN;
          br_lg_d  = BR_LONG;
          br_off_d = BR_OFFSET;
          ready_d  = 1'b0;
          state_d  = S_BRANCH;
          cnt_d    = (br_cyc < 4'h2) ? 4'h1 : br_cyc - 4'h1;
        end
      end
      S_EXEC: begin
        if (cnt_q != 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else if (op_q == `OP_WAIT_FOR_IRQ) begin
          state_d = S_WAIT;
        end else begin
          state_d = S_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      S_WAIT: begin
        if (irq_seen) begin
          state_d = S_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      S_BRANCH: begin
        if (cnt_q != 4'h1) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = S_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = S_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // register file updates
  // --------------------------------------------------------------------
  always @* begin
    wacc_d  = wacc_q;
    sacc_d  = sacc_q;
    idx1_d  = idx1_q;
    idx2_d  = idx2_q;
    idx3_d  = idx3_q;
    ext1_d  = ext1_q;
    ext2_d  = ext2_q;
    ext3_d  = ext3_q;
    sext_d  = sext_q;
    sp_d    = sp_q;
    flags_d = flags_q;
    pc_d    = pc_q;
    stk_w   = 20'h00000;
    pc_next = {flags_q[`PC_EXT_MSB:0], pc_q};
    if (REG_WR) begin
      case (REG_ADDR)
        `REG_WORD_ACC:    wacc_d  = REG_WDATA;
        `REG_SECOND_ACC:  sacc_d  = REG_WDATA;
        `REG_INDEX_ONE:   idx1_d  = REG_WDATA;
        `REG_INDEX_TWO:   idx2_d  = REG_WDATA;
        `REG_INDEX_THREE: idx3_d  = REG_WDATA;
        `REG_EXTS: begin
          ext1_d = REG_WDATA[3:0];
          ext2_d = REG_WDATA[7:4];
          ext3_d = REG_WDATA[11:8];
          sext_d = REG_WDATA[15:12];
        end
        `REG_STACK_PTR:   sp_d    = REG_WDATA;
        `REG_FLAGS:       flags_d = REG_WDATA;
        `REG_PC:          pc_d    = REG_WDATA;
        default: begin
        end
      endcase
    end
    if (apply) begin
      case (op_q)
        `OP_COPY_IDX2_EXT_TO_LOW: wacc_d[7:0] = {4'h0, ext2_q};
        `OP_COPY_IDX3_EXT_TO_LOW: wacc_d[7:0] = {4'h0, ext3_q};
        `OP_COPY_IDX3_TO_IDX2: begin
          idx2_d = idx3_q;
          ext2_d = ext3_q;
        end
        `OP_COPY_IDX2_TO_IDX1: begin
          idx1_d = idx2_q;
          ext1_d = ext2_q;
        end
        `OP_COPY_IDX2_TO_IDX3: begin
          idx3_d = idx2_q;
          ext3_d = ext2_q;
        end
        `OP_COPY_IDX3_TO_IDX1: begin
          idx1_d = idx3_q;
          ext1_d = ext3_q;
        end
        `OP_COPY_IDX1_TO_STACK: begin
          stk_w  = {ext1_q, idx1_q} - `STACK_ADJUST;
          sext_d = stk_w[19:16];
          sp_d   = stk_w[15:0];
        end
        `OP_COPY_IDX2_TO_STACK: begin
          stk_w  = {ext2_q, idx2_q} - `STACK_ADJUST;
          sext_d = stk_w[19:16];
          sp_d   = stk_w[15:0];
        end
        `OP_COPY_IDX3_TO_STACK: begin
          stk_w  = {ext3_q, idx3_q} - `STACK_ADJUST;
          sext_d = stk_w[19:16];
          sp_d   = stk_w[15:0];
        end
        `OP_SWAP_BYTE_ACCS:  wacc_d = {wacc_q[7:0], wacc_q[15:8]};
        `OP_SWAP_WORD_ACCS: begin
          wacc_d = sacc_q;
          sacc_d = wacc_q;
        end
        `OP_SWAP_WACC_IDX1: begin
          wacc_d = idx1_q;
          idx1_d = wacc_q;
        end
        `OP_SWAP_WACC_IDX2: begin
          wacc_d = idx2_q;
          idx2_d = wacc_q;
        end
        `OP_SWAP_WACC_IDX3: begin
          wacc_d = idx3_q;
          idx3_d = wacc_q;
        end
        `OP_SWAP_SACC_IDX1: begin
          sacc_d = idx1_q;
          idx1_d = sacc_q;
        end
        `OP_SWAP_SACC_IDX2: begin
          sacc_d = idx2_q;
          idx2_d = sacc_q;
        end
        `OP_SWAP_SACC_IDX3: begin
          sacc_d = idx3_q;
          idx3_d = sacc_q;
        end
        default: begin
        end
      endcase
    end
    if ((state_q == S_BRANCH) && (cnt_q == 4'h1) && br_tk_q) begin
      if (br_lg_q)
        pc_next = pc_next + {{4{br_off_q[15]}}, br_off_q};
      else
        pc_next = pc_next + {12'h000, br_off_q[7:0]};
      pc_d = pc_next[15:0];
      flags_d[`PC_EXT_MSB:0] = pc_next[19:16];
    end
    if (FLAG_REQ) begin
      case (FLAG_CONV)
        `CONV_RESULT:       flags_d[15:`FLAGS_UPPER_LSB] = FLAG_DATA[15:`FLAGS_UPPER_LSB];
        `CONV_STACK_ALL:    flags_d = FLAG_DATA;
        `CONV_STACK_PC_EXT: flags_d[`PC_EXT_MSB:0] = FLAG_DATA[`PC_EXT_MSB:0];
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // flip-flops
  // --------------------------------------------------------------------
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q  <= S_IDLE;
      cnt_q    <= 4'h0;
      op_q     <= `RESET_WORD;
      ready_q  <= 1'b1;
      done_q   <= 1'b0;
      br_tk_q  <= 1'b0;
      br_lg_q  <= 1'b0;
      br_off_q <= `RESET_WORD;
      wacc_q   <= `RESET_WORD;
      sacc_q   <= `RESET_WORD;
      idx1_q   <= `RESET_WORD;
      idx2_q   <= `RESET_WORD;
      idx3_q   <= `RESET_WORD;
      ext1_q   <= `RESET_EXT;
      ext2_q   <= `RESET_EXT;
      ext3_q   <= `RESET_EXT;
      sext_q   <= `RESET_EXT;
      sp_q     <= `RESET_WORD;
      flags_q  <= `RESET_WORD;
      pc_q     <= `RESET_WORD;
      rdata_q  <= `RESET_WORD;
      ea_q     <= 20'h00000;
      ea_vld_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      op_q     <= op_d;
      ready_q  <= ready_d;
      done_q   <= done_d;
      br_tk_q  <= br_tk_d;
      br_lg_q  <= br_lg_d;
      br_off_q <= br_off_d;
      wacc_q   <= wacc_d;
      sacc_q   <= sacc_d;
      idx1_q   <= idx1_d;
      idx2_q   <= idx2_d;
      idx3_q   <= idx3_d;
      ext1_q   <= ext1_d;
      ext2_q   <= ext2_d;
      ext3_q   <= ext3_d;
      sext_q   <= sext_d;
      sp_q     <= sp_d;
      flags_q  <= flags_d;
      pc_q     <= pc_d;
      ea_vld_q <= EA_REQ;
      if (EA_REQ)
        ea_q <= ea_w;
      if (REG_RD) begin
        case (REG_ADDR)
          `REG_WORD_ACC:    rdata_q <= wacc_q;
          `REG_SECOND_ACC:  rdata_q <= sacc_q;
          `REG_INDEX_ONE:   rdata_q <= idx1_q;
          `REG_INDEX_TWO:   rdata_q <= idx2_q;
          `REG_INDEX_THREE: rdata_q <= idx3_q;
          `REG_EXTS:        rdata_q <= {sext_q, ext3_q, ext2_q, ext1_q};
          `REG_STACK_PTR:   rdata_q <= sp_q;
          `REG_FLAGS:       rdata_q <= flags_q;
          `REG_PC:          rdata_q <= pc_q;
          `REG_STATUS:      rdata_q <= {12'h000, state_q};
          default:          rdata_q <= `RESET_WORD;
        endcase
      end else begin
        rdata_q <= `RESET_WORD;
      end
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign OP_READY  = ready_q;
  assign OP_DONE   = done_q;
  assign WAITING   = state_q[2];
  assign EA_VALID  = ea_vld_q;
  assign EA        = ea_q;
  assign REG_RDATA = rdata_q;

endmodule

/* File: logic/ea_gen.v */
// Purpose: effective address adder for the indexed addressing modes
// Assumes: base is the 20-bit extended index register
// Notes:   purely combinational
`include "xfer_exchange_defines.vh"

module ea_gen (
  // mode and operands
  input  wire [1:0]  mode,
  input  wire [19:0] base,
  input  wire [19:0] operand,
  // result
  output reg  [19:0] ea
);

  always @* begin
    case (mode)
      `MODE_SHORT_INDEXED: ea = base + {12'h000, operand[7:0]};
      `MODE_WORD_INDEXED:  ea = base + {{4{operand[15]}}, operand[15:0]};
      `MODE_LONG_INDEXED:  ea = base + operand;
      default:             ea = base;
    endcase
  end

endmodule

/* File: logic/xfer_exchange_defines.vh */
// Purpose: constants for the transfer/exchange decode block
// Assumes: 16-bit data, 20-bit extended addresses, 100 MHz CLK
// Notes:   included by every design file of the block
//
// Overview of operation
// - opcode 37ad: index_two_ext into low acc bits 3:0, bits 7:4 zero, 2 cycles
// - opcode 37ae: index_three_ext into low acc bits 3:0, bits 7:4 zero, 2 cycles
// - opcode 275e: copy index_three into index_two, 2 cycles, flags kept
// - opcode 27f3: wait for interrupt, 8 cycles accounted, flags kept
// - opcode 371a: swap upper and lower byte accumulators, 2 cycles
// - opcode 277a: swap word_acc and second_word_acc, 2 cycles
// - 37cc/37dc/37ec: swap word_acc with index one/two/three, 2 cycles
// - 374c/375c/376c: swap second_word_acc with index one/two/three, 2 cycles
// - result convention: flags bits 15:4 from result, pc_ext kept
// - conditional branch uses first count when taken, second when not
// - stack restore convention: all sixteen flag bits from stacked word
// - pc_ext convention: only pc_ext from stacked value, rest kept
// - short indexed mode adds unsigned 8-bit offset to index
// - word indexed mode sign-extends 16-bit offset before adding
// - long indexed mode adds signed 20-bit offset to index
// - short branch offset 8-bit unsigned, long branch 16-bit signed
`ifndef XFER_EXCHANGE_DEFINES_VH
`define XFER_EXCHANGE_DEFINES_VH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define OP_COPY_IDX2_EXT_TO_LOW  16'h37ad
`define OP_COPY_IDX3_EXT_TO_LOW  16'h37ae
`define OP_COPY_IDX3_TO_IDX2     16'h275e
`define OP_COPY_IDX2_TO_IDX1     16'h274d
`define OP_COPY_IDX2_TO_IDX3     16'h276d
`define OP_COPY_IDX3_TO_IDX1     16'h274e
`define OP_COPY_IDX1_TO_STACK    16'h374e
`define OP_COPY_IDX2_TO_STACK    16'h375e
`define OP_COPY_IDX3_TO_STACK    16'h376e
`define OP_WAIT_FOR_IRQ          16'h27f3
`define OP_SWAP_BYTE_ACCS        16'h371a
`define OP_SWAP_WORD_ACCS        16'h277a
`define OP_SWAP_WACC_IDX1        16'h37cc
`define OP_SWAP_WACC_IDX2        16'h37dc
`define OP_SWAP_WACC_IDX3        16'h37ec
`define OP_SWAP_SACC_IDX1        16'h374c
`define OP_SWAP_SACC_IDX2        16'h375c
`define OP_SWAP_SACC_IDX3        16'h376c

// ----------------------------------------------------------------------
// timing counts (cycles) and stack adjust
// ----------------------------------------------------------------------
`define CYC_XFER                 4'h2
`define CYC_WAIT                 4'h8
`define STACK_ADJUST             20'h00002

// ----------------------------------------------------------------------
// addressing modes and flag conventions
// ----------------------------------------------------------------------
`define MODE_SHORT_INDEXED       2'h0
`define MODE_WORD_INDEXED        2'h1
`define MODE_LONG_INDEXED        2'h2
`define CONV_RESULT              2'h1
`define CONV_STACK_ALL           2'h2
`define CONV_STACK_PC_EXT        2'h3
`define PC_EXT_MSB               3
`define FLAGS_UPPER_LSB          4

// ----------------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------------
`define REG_WORD_ACC             4'h0
`define REG_SECOND_ACC           4'h1
`define REG_INDEX_ONE            4'h2
`define REG_INDEX_TWO            4'h3
`define REG_INDEX_THREE          4'h4
`define REG_EXTS                 4'h5
`define REG_STACK_PTR            4'h6
`define REG_FLAGS                4'h7
`define REG_PC                   4'h8
`define REG_STATUS               4'h9
`define RESET_WORD               16'h0000
`define RESET_EXT                4'h0

`endif
